//--- mspl_pkg.sv
// Constants, carriers and states shared by the preset loader and its testbench
package mspl_pkg;
  // Framing and status byte values
  localparam logic [7:0] SX_START = 8'hF0;
  localparam logic [7:0] SX_STOP = 8'hF7;
  localparam logic [7:0] RT_MIN = 8'hF8;
  // Message type byte after the identity
  localparam logic [7:0] TYPE_SINGLE = 8'h01;
  localparam logic [7:0] TYPE_ALL = 8'h02;
  // Identity byte: value is arbitrary
  localparam logic [7:0] MFR_ID_DEFAULT = 8'h5A;
  // Preset geometry
  localparam int NUM_PRESETS = 16;
  localparam int PRESET_BYTES_DEFAULT = 32;
  localparam int SLOT_W = 5;
  localparam logic [SLOT_W-1:0] WORK_SLOT = 5'h10;
  localparam logic [SLOT_W-1:0] STAGE_SLOT = 5'h11;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_CYC_DEFAULT = BLINK_HALF_MS * (CLK_HZ / 1000);
  // Front-panel buttons, one bit each
  typedef struct packed {
    logic recall;
    logic solo;
    logic other;
  } mspl_btn_t;
  // Front-panel indicators
  typedef struct packed {
    logic recall;
    logic solo;
    logic [15:0] mute;
    logic [15:0] red;
  } mspl_led_t;
  // Loader states
  typedef enum {
    ST_IDLE, ST_RECALL, ST_ARMED, ST_SKIP, ST_ID, ST_TYPE,
    ST_DATA, ST_COPY, ST_END, ST_OK, ST_ERR
  } mspl_state_t;
endpackage

//--- mspl_mem.sv
// Preset byte memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module mspl_mem #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [DW-1:0] rdata_out
);
  // Storage array, not reset: contents survive loader resets
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule // mspl_mem
`default_nettype wire

//--- mspl_loader.sv
// Exclusive-message preset loader: panel control, framing, staging and copy
`timescale 1ns/1ns
`default_nettype none
module mspl_loader
  import mspl_pkg::*;
#(
  parameter logic [7:0] MFR_ID = MFR_ID_DEFAULT,
  parameter int PRESET_BYTES = PRESET_BYTES_DEFAULT,
  parameter int unsigned BLINK_CYC = BLINK_CYC_DEFAULT,
  localparam int BW = $clog2(PRESET_BYTES),
  localparam int AW = SLOT_W + BW
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire mspl_btn_t btn_in,
  input wire logic local_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  input wire logic [AW-1:0] host_raddr_in,
  output logic [7:0] host_rdata_out,
  output logic [7:0] thru_byte_out,
  output logic thru_valid_out,
  output mspl_led_t led_out
);
  // Byte counters must address a power-of-two preset exactly
  if (PRESET_BYTES < 2 || (1 << BW) != PRESET_BYTES || BLINK_CYC < 1) begin : g_bad_param
    $error("PRESET_BYTES must be a power of two above 1, BLINK_CYC at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  mspl_btn_t btn_s1_ff, btn_s2_ff, btn_prev_ff; // Button sync chain
  logic local_s1_ff, local_s2_ff, local_prev_ff; // Switch sync chain
  logic press; // Any button newly pressed
  logic sw_change; // Switch moved
  // Two stages before any logic looks at panel pins; thru echo rides along
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      {btn_s1_ff, btn_s2_ff, btn_prev_ff} <= '0;
      {local_s1_ff, local_s2_ff, local_prev_ff} <= '0;
      {thru_byte_out, thru_valid_out} <= '0;
    end else begin
      btn_s1_ff <= btn_in;
      btn_s2_ff <= btn_s1_ff;
      btn_prev_ff <= btn_s2_ff;
      local_s1_ff <= local_in;
      local_s2_ff <= local_s1_ff;
      local_prev_ff <= local_s2_ff;
      // Thru path ignores the switch and the loader state
      thru_byte_out <= rx_byte_in;
      thru_valid_out <= rx_valid_in;
    end
  end
  assign press = |(btn_s2_ff & ~btn_prev_ff);
  assign sw_change = local_s2_ff ^ local_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Loader state machine
  mspl_state_t state_ff, nxt_state; // Loader state
  logic all_mode_ff, nxt_all_mode; // All-preset file in progress
  logic [3:0] preset_ff, nxt_preset; // Preset position being received
  logic [BW-1:0] byte_ff, nxt_byte; // Byte within preset
  logic [BW:0] copy_ff, nxt_copy; // Copy pipeline step
  logic [15:0] progress_ff, nxt_progress; // Presets committed so far
  logic pend_ff, nxt_pend; // Abort seen during copy
  logic rt, stat, abort, rx_state, mem_we; // Byte class, exit, write strobe
  logic [SLOT_W-1:0] wslot, tslot; // Written slot, copy target
  logic [BW-1:0] wbyte; // Written byte index
  logic [7:0] wdata; // Written byte
  logic [AW-1:0] raddr; // Shared read address
  assign rt = rx_byte_in >= RT_MIN;
  assign stat = rx_byte_in[7] && !rt;
  assign abort = press || sw_change || !local_s2_ff;
  // Receive states run from armed through end of message
  assign rx_state = !(state_ff inside {ST_IDLE, ST_RECALL, ST_OK, ST_ERR});
  assign tslot = all_mode_ff ? {1'b0, preset_ff} : WORK_SLOT;
  // Next state, counters and memory strobes
  always_comb begin
    nxt_state = state_ff;
    nxt_all_mode = all_mode_ff;
    nxt_preset = preset_ff;
    nxt_byte = byte_ff;
    nxt_copy = copy_ff;
    nxt_progress = progress_ff;
    nxt_pend = pend_ff;
    mem_we = 1'b0;
    wslot = STAGE_SLOT;
    wbyte = byte_ff;
    wdata = rx_byte_in;
    case (state_ff)
      ST_IDLE: begin
        if (btn_s2_ff.recall && !btn_prev_ff.recall) begin
          nxt_state = ST_RECALL;
        end
      end
      ST_RECALL: begin
        // Solo arms only from recall mode and in local position
        if (btn_s2_ff.solo && !btn_prev_ff.solo && local_s2_ff) begin
          nxt_state = ST_ARMED;
        end else if (press) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ARMED: begin
        if (abort) begin
          nxt_state = ST_IDLE;
        end else if (rx_valid_in && rx_byte_in == SX_START) begin
          nxt_state = ST_ID;
        end
      end
      ST_ID: begin
        if (abort) begin
          nxt_state = ST_IDLE;
        end else if (rx_valid_in && !rt) begin
          // Foreign identity: skip to end, armed state untouched
          nxt_state = (rx_byte_in == MFR_ID) ? ST_TYPE : ST_SKIP;
        end
      end
      ST_SKIP: begin
        if (abort) begin
          nxt_state = ST_IDLE;
        end else if (rx_valid_in && stat) begin
          nxt_state = (rx_byte_in == SX_START) ? ST_ID : ST_ARMED;
        end
      end
      ST_TYPE: begin
        nxt_preset = '0;
        nxt_byte = '0;
        nxt_progress = '0;
        nxt_pend = 1'b0;
        if (abort) begin
          nxt_state = ST_IDLE;
        end else if (rx_valid_in && !rt) begin
          nxt_all_mode = rx_byte_in == TYPE_ALL;
          if (rx_byte_in == TYPE_ALL || rx_byte_in == TYPE_SINGLE) begin
            nxt_state = ST_DATA;
          end else begin
            nxt_state = ST_ERR;
          end
        end
      end
      ST_DATA: begin
        if (abort) begin
          nxt_state = ST_IDLE;
        end else if (rx_valid_in && stat) begin
          nxt_state = ST_ERR;
        end else if (rx_valid_in && !rt) begin
          // Bytes land in staging; live slots change only by whole preset
          mem_we = 1'b1;
          nxt_byte = byte_ff + 1'b1;
          nxt_copy = '0;
          if (byte_ff == BW'(PRESET_BYTES - 1)) begin
            nxt_state = ST_COPY;
          end
        end
      end
      ST_COPY: begin
        // Not abortable: a half-copied slot would break preservation
        nxt_pend = pend_ff || abort;
        nxt_copy = copy_ff + 1'b1;
        if (copy_ff != '0) begin
          mem_we = 1'b1;
          wslot = tslot;
          wbyte = BW'(copy_ff - 1'b1);
          wdata = host_rdata_out;
        end
        if (copy_ff == (BW+1)'(PRESET_BYTES)) begin
          if (all_mode_ff) begin
            nxt_progress[preset_ff] = 1'b1;
          end
          nxt_byte = '0;
          if (pend_ff || abort) begin
            nxt_state = ST_IDLE;
          end else if (all_mode_ff && preset_ff != 4'(NUM_PRESETS - 1)) begin
            nxt_preset = preset_ff + 1'b1;
            nxt_state = ST_DATA;
          end else begin
            nxt_state = ST_END;
          end
        end
      end
      ST_END: begin
        if (abort) begin
          nxt_state = ST_IDLE;
        end else if (rx_valid_in && !rt) begin
          nxt_state = (rx_byte_in == SX_STOP) ? ST_OK : ST_ERR;
        end
      end
      ST_OK, ST_ERR: begin
        if (press) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end
  // Host read data shows staging bytes while a copy owns the read port
  assign raddr = (state_ff == ST_COPY) ? {STAGE_SLOT, copy_ff[BW-1:0]} : host_raddr_in;
  mspl_mem #(.AW(AW), .DW(8)) u_mem (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .we_in(mem_we),
    .waddr_in({wslot, wbyte}),
    .wdata_in(wdata),
    .raddr_in(raddr),
    .rdata_out(host_rdata_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Blink timer and indicators
  logic [31:0] blink_ff, nxt_blink; // Half-period counter
  logic phase_ff, nxt_phase; // Blink phase
  mspl_led_t nxt_led; // Indicator next value
  // Shared blink phase and indicator decode
  always_comb begin
    nxt_blink = blink_ff + 32'h0000_0001;
    nxt_phase = phase_ff;
    if (blink_ff >= 32'(BLINK_CYC - 1)) begin
      nxt_blink = '0;
      nxt_phase = !phase_ff;
    end
    nxt_led = '0;
    nxt_led.recall = (state_ff == ST_RECALL) && phase_ff;
    nxt_led.solo = rx_state && phase_ff;
    if (state_ff == ST_OK) begin
      nxt_led.mute = {16{phase_ff}};
    end else if (rx_state && all_mode_ff) begin
      nxt_led.mute = progress_ff;
    end
    nxt_led.red = {16{phase_ff && state_ff == ST_ERR}};
  end
  // Loader and indicator registers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_ff <= ST_IDLE;
      {all_mode_ff, preset_ff, byte_ff, copy_ff, progress_ff, pend_ff} <= '0;
      {blink_ff, phase_ff, led_out} <= '0;
    end else begin
      state_ff <= nxt_state;
      all_mode_ff <= nxt_all_mode;
      preset_ff <= nxt_preset;
      byte_ff <= nxt_byte;
      copy_ff <= nxt_copy;
      progress_ff <= nxt_progress;
      pend_ff <= nxt_pend;
      blink_ff <= nxt_blink;
      phase_ff <= nxt_phase;
      led_out <= nxt_led;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  chk_thru_echo: assert property (
    rx_valid_in |=> thru_valid_out && thru_byte_out == $past(rx_byte_in))
    else $error("thru did not repeat input byte");
  chk_arm_source: assert property (
    (state_ff == ST_ARMED && $past(state_ff) == ST_RECALL) |-> $past(local_s2_ff))
    else $error("armed without local switch");
  chk_arm_path: assert property (
    (state_ff == ST_ARMED && !($past(state_ff) inside {ST_ARMED, ST_SKIP}))
      |-> $past(state_ff) == ST_RECALL) else $error("armed not from recall mode");
  chk_remote_drop: assert property (
    (rx_state && state_ff != ST_COPY && !local_s2_ff) |=> state_ff == ST_IDLE)
    else $error("reception continued in remote");
  chk_solo_blink: assert property (rx_state |=> led_out.solo == $past(phase_ff))
    else $error("solo indicator wrong while armed");
  chk_foreign_quiet: assert property (
    state_ff == ST_SKIP |-> !mem_we ##1 $stable(progress_ff))
    else $error("foreign message changed loader");
  chk_abort_exit: assert property (
    (rx_state && state_ff != ST_COPY && press) |=> state_ff == ST_IDLE)
    else $error("button did not abort load");
  chk_progress_fill: assert property (
    (progress_ff & 16'(progress_ff + 16'h0001)) == 16'h0000)
    else $error("progress not filled in order");
  chk_live_write: assert property (
    (mem_we && wslot != STAGE_SLOT) |-> state_ff == ST_COPY && wslot == tslot)
    else $error("live slot written outside copy");
  chk_copy_whole: assert property (
    (state_ff == ST_COPY && copy_ff != (BW+1)'(PRESET_BYTES)) |=> state_ff == ST_COPY)
    else $error("copy cut short");
  chk_status_hold: assert property (
    (state_ff inside {ST_OK, ST_ERR} && !press) |=> $stable(state_ff))
    else $error("status left without a press");
  chk_ok_flash: assert property (
    state_ff == ST_OK |=> led_out.mute == {16{$past(phase_ff)}})
    else $error("success flash wrong");
  chk_err_flash: assert property (
    state_ff == ST_ERR |=> led_out.red == {16{$past(phase_ff)}})
    else $error("failure flash wrong");
  chk_bad_status: assert property (
    (state_ff == ST_DATA && rx_valid_in && stat && !abort) |=> state_ff == ST_ERR)
    else $error("status byte in payload not failed");
endmodule // mspl_loader
`default_nettype wire

//--- mspl_midi_src.sv
// Behavioural model of the external storage device feeding the MIDI input
`timescale 1ns/1ns
`default_nettype none
module mspl_midi_src (
  input wire logic clk_sys_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out
);
  // Quiet line before the first byte
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One byte, then a gap; the bench first calls this before the loader is armed
  task automatic send_byte(input logic [7:0] b, input int gap);
    @(posedge clk_sys_in);
    rx_byte_out <= b;
    rx_valid_out <= 1'b1;
    @(posedge clk_sys_in);
    rx_valid_out <= 1'b0;
    // Inverted stale value catches a parser that ignores the strobe
    rx_byte_out <= ~b;
    repeat (gap - 2) @(posedge clk_sys_in);
  endtask
endmodule // mspl_midi_src
`default_nettype wire

//--- tb_midi_sysex_preset_loader.sv
// Self-checking testbench for the exclusive-message preset loader
`timescale 1ns/1ns
`default_nettype none
module tb_midi_sysex_preset_loader;
  import mspl_pkg::*;
  localparam int PB = 4; // Short presets keep the run brief
  localparam int BC = 4; // Short blink half period
  localparam int AW = SLOT_W + 2;
  localparam mspl_btn_t B_RECALL = 3'b100;
  localparam mspl_btn_t B_SOLO = 3'b010;
  localparam mspl_btn_t B_OTHER = 3'b001;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  mspl_btn_t btn_in = '0;
  logic local_in = 1'b0;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [AW-1:0] host_raddr_in = '0;
  logic [7:0] host_rdata_out;
  logic [7:0] thru_byte_out;
  logic thru_valid_out;
  mspl_led_t led_out;
  int err_total = 0;
  int n_compared = 0;
  int gap_cyc = 40; // Byte spacing, well above the copy time
  logic [31:0] lfsr_ff = 32'hB166;
  logic [7:0] exp_q[$]; // Expected thru bytes, oldest first
  logic [7:0] mem_exp [0:(18*PB)-1]; // Expected preset memory
  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #25 clk_sys_in = ~clk_sys_in;
  mspl_loader #(.PRESET_BYTES(PB), .BLINK_CYC(BC)) dut (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .btn_in(btn_in),
    .local_in(local_in),
    .rx_byte_in(rx_byte),
    .rx_valid_in(rx_valid),
    .host_raddr_in(host_raddr_in),
    .host_rdata_out(host_rdata_out),
    .thru_byte_out(thru_byte_out),
    .thru_valid_out(thru_valid_out),
    .led_out(led_out)
  );
  mspl_midi_src src (
    .clk_sys_in(clk_sys_in),
    .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Every byte sent is noted for the thru watcher first
  task automatic tx(input logic [7:0] b);
    exp_q.push_back(b);
    src.send_byte(b, gap_cyc);
  endtask
  // Held long enough to pass the two-stage synchroniser
  task automatic press(input mspl_btn_t b);
    @(posedge clk_sys_in) btn_in <= b;
    repeat (4) @(posedge clk_sys_in);
    btn_in <= '0;
    repeat (6) @(posedge clk_sys_in);
  endtask
  // Window covering two blink periods: 0 recall, 1 solo, 2 mute all, 3 red all
  task automatic wait_led(input int sel, input logic want);
    logic seen;
    seen = 1'b0;
    repeat (4 * BC + 8) begin
      @(posedge clk_sys_in);
      #1;
      case (sel)
        0: seen = seen | (led_out.recall === 1'b1);
        1: seen = seen | (led_out.solo === 1'b1);
        2: seen = seen | (led_out.mute === 16'hFFFF);
        default: seen = seen | (led_out.red === 16'hFFFF);
      endcase
    end
    check(34'(seen), 34'(want));
  endtask
  task automatic rd_chk(input int a);
    @(posedge clk_sys_in) host_raddr_in <= AW'(a);
    repeat (2) @(posedge clk_sys_in);
    #1 check(34'(host_rdata_out), 34'(mem_exp[a]));
  endtask
  task automatic idle_chk();
    repeat (2) @(posedge clk_sys_in);
    #1 check(34'(led_out), 34'h0);
  endtask
  task automatic arm();
    press(B_RECALL);
    wait_led(0, 1'b1);
    press(B_SOLO);
    wait_led(1, 1'b1);
  endtask
  // Random payload bytes below the status range
  task automatic payload(input int slot);
    for (int b = 0; b < PB; b++) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      mem_exp[slot * PB + b] = {1'b0, lfsr_ff[6:0]};
      tx({1'b0, lfsr_ff[6:0]});
    end
  endtask
  // All-preset file up to count presets, progress checked after each
  task automatic load_all(input int count);
    arm();
    tx(SX_START);
    tx(MFR_ID_DEFAULT);
    tx(TYPE_ALL);
    for (int p = 0; p < count; p++) begin
      payload(p);
      #1 check(34'(led_out.mute), 34'((32'h1 << (p + 1)) - 1));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Thru watcher: each echoed byte takes the oldest note
  always @(negedge clk_sys_in) begin
    if (thru_valid_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("Error at %0t: got %0h expected none", $time, thru_byte_out);
      end else begin
        check(34'(thru_byte_out), 34'(exp_q.pop_front()));
      end
    end
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    err_total++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1 check(34'(led_out), 34'h0);
    tx(8'hF8);
    // Remote position: recall works, arming refused
    press(B_RECALL);
    wait_led(0, 1'b1);
    press(B_SOLO);
    wait_led(1, 1'b0);
    press(B_OTHER);
    wait_led(0, 1'b0);
    @(posedge clk_sys_in) local_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    press(B_SOLO);
    wait_led(1, 1'b0);
    // Single preset behind a foreign message, slow sender
    arm();
    tx(SX_START);
    tx(8'h33);
    tx(TYPE_SINGLE);
    tx(8'h11);
    tx(SX_STOP);
    wait_led(1, 1'b1);
    gap_cyc = 120;
    tx(SX_START);
    tx(MFR_ID_DEFAULT);
    tx(TYPE_SINGLE);
    payload(16);
    tx(SX_STOP);
    gap_cyc = 40;
    wait_led(2, 1'b1);
    for (int b = 0; b < PB; b++) rd_chk(16 * PB + b);
    press(B_OTHER);
    idle_chk();
    // Full all-preset file
    load_all(16);
    tx(SX_STOP);
    wait_led(2, 1'b1);
    for (int a = 0; a < 16 * PB; a++) rd_chk(a);
    press(B_SOLO);
    idle_chk();
    // Abort by switch change after five presets
    load_all(5);
    @(posedge clk_sys_in) local_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    #1 check(34'(led_out), 34'h0);
    for (int a = 0; a < 16 * PB; a++) rd_chk(a);
    @(posedge clk_sys_in) local_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    // Bad type, status byte in payload, wrong length
    for (int c = 0; c < 3; c++) begin
      arm();
      tx(SX_START);
      tx(MFR_ID_DEFAULT);
      tx((c == 0) ? 8'h03 : TYPE_SINGLE);
      if (c == 1) tx(8'h12);
      if (c == 1) tx(8'h90);
      if (c == 2) payload(17);
      if (c == 2) tx(8'h00);
      wait_led(3, 1'b1);
      press(B_OTHER);
      idle_chk();
    end
    repeat (4) @(posedge clk_sys_in);
    check(34'(exp_q.size()), 34'h0);
    close_out();
  end
endmodule // tb_midi_sysex_preset_loader
`default_nettype wire
